// [focus_rf_gain_offset_regs.sv]
// Focus offset, RF gain and RF offset control registers behind AXI4-Lite.
// Summary of operation
// R1 - Word top four bits select registers 2-5.
// R2 - Register 2 bit 11: alternate stretch timing.
// R3 - Register 2 bit 10 low enables focus offset.
// R4 - Register 2 bits 9-5: focus offset fraction.
// R5 - Register 3 bits 11-10: first stage gain.
// R6 - Register 3 bits 9-8: second stage gain.
// R7 - Register 3 bits 7-4: third stage gain.
// R8 - Left code drives left DAC without sum select.
// R9 - Right code drives right DAC without sum select.
// R10 - Sum select, source 0: right code drives both.
// R11 - Sum select, source 1: right code ignored.
// R12 - Sum code unused unless both mode bits set.
// R13 - Both set: sum code to sum, left to phase.
// R14 - Mode bit 0 is the sum input select.
// R15 - Mode bit 11 picks the phase offset source.
// R16 - Registers hold; other selectors change nothing.
// R17 - Routing follows stored fields and mode bits.
module focus_rf_gain_offset_regs
	import rf_ctrl_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// AXI4-Lite write address and data
	input wire logic [ADDR_WIDTH-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// AXI4-Lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [ADDR_WIDTH-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Focus and gain controls
	output logic altStretchTimingMode,
	output logic focusOffsetEnable_n,
	output logic [4:0] focusOffsetFraction,
	output logic [1:0] firstStageGain,
	output logic [1:0] secondStageGain,
	output logic [3:0] thirdStageGain,
	// Routed offset DAC codes
	output logic [CODE_WIDTH-1:0] leftOffsetDac,
	output logic [CODE_WIDTH-1:0] rightOffsetDac,
	output logic [CODE_WIDTH-1:0] phaseOffsetDac,
	output logic [CODE_WIDTH-1:0] sumOffsetDac
);

	// ==========================================================
	// Write channel state
	logic awHeld_reg, awHeld_next, wHeld_reg, wHeld_next;
	logic [ADDR_WIDTH-1:0] waddr_reg, waddr_next;
	logic [31:0] wdat_reg, wdat_next;
	logic [3:0] wstb_reg, wstb_next;
	logic awready_reg, awready_next, wready_reg, wready_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic commit, cmdWrite, modeWrite, fullWord;

	always_comb begin
		awHeld_next = awHeld_reg;
		wHeld_next = wHeld_reg;
		waddr_next = waddr_reg;
		wdat_next = wdat_reg;
		wstb_next = wstb_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		commit = awHeld_reg && wHeld_reg && !bvalid_reg;
		fullWord = (wstb_reg[1:0] == 2'h3);
		cmdWrite = commit && (waddr_reg == ADDR_COMMAND) && fullWord;
		modeWrite = commit && (waddr_reg == ADDR_MODE) && fullWord;
		if (awvalid && awready_reg) begin
			awHeld_next = 1'b1;
			waddr_next = awaddr;
		end
		if (wvalid && wready_reg) begin
			wHeld_next = 1'b1;
			wdat_next = wdata;
			wstb_next = wstrb;
		end
		if (commit) begin
			awHeld_next = 1'b0;
			wHeld_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = (cmdWrite || modeWrite) ? RESP_OKAY : RESP_SLVERR;
		end
		if (bvalid_reg && bready) begin
			bvalid_next = 1'b0;
		end
		awready_next = !awHeld_next && !bvalid_next;
		wready_next = !wHeld_next && !bvalid_next;
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			awHeld_reg <= 1'b0;
			wHeld_reg <= 1'b0;
			waddr_reg <= '0;
			wdat_reg <= 32'h0;
			wstb_reg <= 4'h0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
		end else begin
			awHeld_reg <= awHeld_next;
			wHeld_reg <= wHeld_next;
			waddr_reg <= waddr_next;
			wdat_reg <= wdat_next;
			wstb_reg <= wstb_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
		end
	end

	// ==========================================================
	// Control word storage
	logic [3:0] strobe;
	logic [WORD_WIDTH-1:0] cmdWord;
	logic altStretch_reg, altStretch_next, focusEnN_reg, focusEnN_next;
	logic [4:0] fraction_reg, fraction_next;
	logic [1:0] gain1_reg, gain1_next, gain2_reg, gain2_next;
	logic [3:0] gain3_reg, gain3_next;
	logic [CODE_WIDTH-1:0] leftCode_reg, leftCode_next, rightCode_reg, rightCode_next;
	logic [CODE_WIDTH-1:0] sumCode_reg, sumCode_next;
	logic sumSel_reg, sumSel_next, phaseSrc_reg, phaseSrc_next;
	logic [CODE_WIDTH-1:0] leftDac_next, rightDac_next, phaseDac_next, sumDac_next;
	logic [CODE_WIDTH-1:0] leftDac_reg, rightDac_reg, phaseDac_reg, sumDac_reg;

	assign cmdWord = wdat_reg[WORD_WIDTH-1:0];

	control_word_decoder decoder (
		.wordValid(cmdWrite),
		.word(cmdWord),
		.writeStrobe(strobe)
	);

	always_comb begin
		altStretch_next = altStretch_reg;
		focusEnN_next = focusEnN_reg;
		fraction_next = fraction_reg;
		gain1_next = gain1_reg;
		gain2_next = gain2_reg;
		gain3_next = gain3_reg;
		leftCode_next = leftCode_reg;
		rightCode_next = rightCode_reg;
		sumCode_next = sumCode_reg;
		sumSel_next = sumSel_reg;
		phaseSrc_next = phaseSrc_reg;
		if (strobe[0]) begin
			altStretch_next = cmdWord[ALT_STRETCH_BIT]; // R2
			focusEnN_next = cmdWord[FOCUS_EN_N_BIT]; // R3
			fraction_next = cmdWord[FRACTION_HI:FRACTION_LO]; // R4
		end
		if (strobe[1]) begin
			gain1_next = cmdWord[GAIN1_HI:GAIN1_LO]; // R5
			gain2_next = cmdWord[GAIN2_HI:GAIN2_LO]; // R6
			gain3_next = cmdWord[GAIN3_HI:GAIN3_LO]; // R7
		end
		if (strobe[2]) begin
			leftCode_next = cmdWord[LEFT_HI:LEFT_LO]; // R8
			rightCode_next = cmdWord[RIGHT_HI:RIGHT_LO]; // R9
		end
		if (strobe[3]) begin
			sumCode_next = cmdWord[SUM_HI:SUM_LO]; // R12
		end
		if (modeWrite) begin
			sumSel_next = wdat_reg[MODE_SUM_BIT]; // R14
			phaseSrc_next = wdat_reg[MODE_SRC_BIT]; // R15
		end
	end

	// Routing from next values keeps the DAC flops in step with the fields.
	offset_router router (
		.sumInputSelect(sumSel_next),
		.phaseOffsetSourceSelect(phaseSrc_next),
		.leftOffsetCode(leftCode_next),
		.rightOffsetCode(rightCode_next),
		.sumOffsetCode(sumCode_next),
		.leftDac(leftDac_next),
		.rightDac(rightDac_next),
		.phaseDac(phaseDac_next),
		.sumDac(sumDac_next)
	);

	always_ff @(posedge mclk) begin
		if (srst) begin
			altStretch_reg <= RST_ALT_STRETCH;
			focusEnN_reg <= RST_FOCUS_EN_N;
			fraction_reg <= RST_FRACTION;
			gain1_reg <= RST_GAIN1;
			gain2_reg <= RST_GAIN2;
			gain3_reg <= RST_GAIN3;
			leftCode_reg <= RST_CODE;
			rightCode_reg <= RST_CODE;
			sumCode_reg <= RST_CODE;
			sumSel_reg <= RST_MODE_BIT;
			phaseSrc_reg <= RST_MODE_BIT;
			leftDac_reg <= RST_CODE;
			rightDac_reg <= RST_CODE;
			phaseDac_reg <= RST_CODE;
			sumDac_reg <= RST_CODE;
		end else begin
			altStretch_reg <= altStretch_next;
			focusEnN_reg <= focusEnN_next;
			fraction_reg <= fraction_next;
			gain1_reg <= gain1_next;
			gain2_reg <= gain2_next;
			gain3_reg <= gain3_next;
			leftCode_reg <= leftCode_next;
			rightCode_reg <= rightCode_next;
			sumCode_reg <= sumCode_next;
			sumSel_reg <= sumSel_next;
			phaseSrc_reg <= phaseSrc_next;
			leftDac_reg <= leftDac_next; // R17
			rightDac_reg <= rightDac_next; // R17
			phaseDac_reg <= phaseDac_next; // R17
			sumDac_reg <= sumDac_next; // R17
		end
	end

	// ==========================================================
	// Read channel
	logic arready_reg, arready_next, rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0] rresp_reg, rresp_next;

	always_comb begin
		arready_next = arready_reg;
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		if (arvalid && arready_reg) begin
			arready_next = 1'b0;
			rvalid_next = 1'b1;
			rresp_next = RESP_OKAY;
			rdata_next = 32'h0;
			if (araddr == ADDR_FOCUS) begin
				rdata_next[15:0] = {SEL_FOCUS, altStretch_reg, focusEnN_reg, fraction_reg, 5'h00};
			end else if (araddr == ADDR_GAINS) begin
				rdata_next[15:0] = {SEL_GAINS, gain1_reg, gain2_reg, gain3_reg, 4'h0};
			end else if (araddr == ADDR_LR_OFFSETS) begin
				rdata_next[15:0] = {SEL_LR_OFFSETS, leftCode_reg, rightCode_reg};
			end else if (araddr == ADDR_SUM_OFFSET) begin
				rdata_next[15:0] = {SEL_SUM_OFFSET, 6'h00, sumCode_reg};
			end else if (araddr == ADDR_MODE) begin
				rdata_next[MODE_SUM_BIT] = sumSel_reg;
				rdata_next[MODE_SRC_BIT] = phaseSrc_reg;
			end else if (araddr == ADDR_ROUTED) begin
				rdata_next[23:0] = {leftDac_reg, rightDac_reg, phaseDac_reg, sumDac_reg};
			end else if (araddr != ADDR_COMMAND) begin
				rresp_next = RESP_SLVERR;
			end
		end
		if (rvalid_reg && rready) begin
			rvalid_next = 1'b0;
			arready_next = 1'b1;
		end
		if (!arready_reg && !rvalid_reg) begin
			arready_next = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0;
			rresp_reg <= RESP_OKAY;
		end else begin
			arready_reg <= arready_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
		end
	end

	// ==========================================================
	// Outputs
	assign awready = awready_reg;
	assign wready = wready_reg;
	assign bvalid = bvalid_reg;
	assign bresp = bresp_reg;
	assign arready = arready_reg;
	assign rvalid = rvalid_reg;
	assign rdata = rdata_reg;
	assign rresp = rresp_reg;
	assign altStretchTimingMode = altStretch_reg;
	assign focusOffsetEnable_n = focusEnN_reg;
	assign focusOffsetFraction = fraction_reg;
	assign firstStageGain = gain1_reg;
	assign secondStageGain = gain2_reg;
	assign thirdStageGain = gain3_reg;
	assign leftOffsetDac = leftDac_reg;
	assign rightOffsetDac = rightDac_reg;
	assign phaseOffsetDac = phaseDac_reg;
	assign sumOffsetDac = sumDac_reg;

	// ==========================================================
	// Assertions
	a_focus_fields: assert property (@(posedge mclk) disable iff (srst) // R2
		strobe[0] |=> (altStretchTimingMode == $past(cmdWord[ALT_STRETCH_BIT]))
			&& (focusOffsetFraction == $past(cmdWord[FRACTION_HI:FRACTION_LO])))
		else $error("Focus register fields not stored.");
	a_focus_enable: assert property (@(posedge mclk) disable iff (srst) // R3
		cmdWrite && (cmdWord[SEL_HI:SEL_LO] == SEL_FOCUS)
			|=> focusOffsetEnable_n == $past(cmdWord[FOCUS_EN_N_BIT]))
		else $error("Focus offset enable not stored.");
	a_gain_fields: assert property (@(posedge mclk) disable iff (srst) // R5
		strobe[1] |=> (firstStageGain == $past(cmdWord[GAIN1_HI:GAIN1_LO]))
			&& (secondStageGain == $past(cmdWord[GAIN2_HI:GAIN2_LO]))
			&& (thirdStageGain == $past(cmdWord[GAIN3_HI:GAIN3_LO])))
		else $error("Gain fields not stored.");
	a_other_selector: assert property (@(posedge mclk) disable iff (srst) // R16
		cmdWrite && (strobe == 4'h0) |=> $stable(leftCode_reg) && $stable(sumCode_reg)
			&& $stable(gain3_reg) && $stable(fraction_reg))
		else $error("Unaddressed word changed a register.");
	a_left_right_route: assert property (@(posedge mclk) disable iff (srst) // R8
		!sumSel_reg |-> (leftOffsetDac == leftCode_reg) && (rightOffsetDac == rightCode_reg))
		else $error("Left or right DAC not from its field.");
	a_shared_route: assert property (@(posedge mclk) disable iff (srst) // R10
		sumSel_reg && !phaseSrc_reg
			|-> (phaseOffsetDac == rightCode_reg) && (sumOffsetDac == rightCode_reg))
		else $error("Phase and sum DACs not shared.");
	a_split_route: assert property (@(posedge mclk) disable iff (srst) // R13
		sumSel_reg && phaseSrc_reg
			|-> (sumOffsetDac == sumCode_reg) && (phaseOffsetDac == leftCode_reg))
		else $error("Sum or phase DAC not split.");
	a_mode_follow: assert property (@(posedge mclk) disable iff (srst) // R17
		modeWrite ##1 sumSel_reg |-> (leftOffsetDac == 6'h00) && (rightOffsetDac == 6'h00))
		else $error("Left and right DACs not released.");
	a_write_answer: assert property (@(posedge mclk) disable iff (srst) // R1
		commit |=> bvalid && (bresp == (($past(cmdWrite) || $past(modeWrite))
			? RESP_OKAY : RESP_SLVERR)))
		else $error("Write response missing or wrong.");

endmodule

// [rf_ctrl_pkg.sv]
// Constants shared by the focus, RF gain and RF offset control block.
package rf_ctrl_pkg;

	// ==========================================================
	// Control word layout
	localparam int WORD_WIDTH = 16;
	localparam int SEL_HI = 15;
	localparam int SEL_LO = 12;
	localparam logic [3:0] SEL_FOCUS = 4'h2;
	localparam logic [3:0] SEL_GAINS = 4'h3;
	localparam logic [3:0] SEL_LR_OFFSETS = 4'h4;
	localparam logic [3:0] SEL_SUM_OFFSET = 4'h5;

	// ==========================================================
	// Field positions
	localparam int ALT_STRETCH_BIT = 11;
	localparam int FOCUS_EN_N_BIT = 10;
	localparam int FRACTION_HI = 9;
	localparam int FRACTION_LO = 5;
	localparam int GAIN1_HI = 11;
	localparam int GAIN1_LO = 10;
	localparam int GAIN2_HI = 9;
	localparam int GAIN2_LO = 8;
	localparam int GAIN3_HI = 7;
	localparam int GAIN3_LO = 4;
	localparam int LEFT_HI = 11;
	localparam int LEFT_LO = 6;
	localparam int RIGHT_HI = 5;
	localparam int RIGHT_LO = 0;
	localparam int SUM_HI = 5;
	localparam int SUM_LO = 0;
	localparam int MODE_SUM_BIT = 0;
	localparam int MODE_SRC_BIT = 11;
	localparam int CODE_WIDTH = 6;

	// ==========================================================
	// Bus map: register index times four gives the byte address.
	localparam int ADDR_WIDTH = 8;
	localparam logic [7:0] ADDR_FOCUS = 8'h08;
	localparam logic [7:0] ADDR_GAINS = 8'h0c;
	localparam logic [7:0] ADDR_LR_OFFSETS = 8'h10;
	localparam logic [7:0] ADDR_SUM_OFFSET = 8'h14;
	localparam logic [7:0] ADDR_COMMAND = 8'h40;
	localparam logic [7:0] ADDR_MODE = 8'h44;
	localparam logic [7:0] ADDR_ROUTED = 8'h48;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// Reset values
	localparam logic RST_ALT_STRETCH = 1'h0;
	localparam logic RST_FOCUS_EN_N = 1'h1;
	localparam logic [4:0] RST_FRACTION = 5'h00;
	localparam logic [1:0] RST_GAIN1 = 2'h0;
	localparam logic [1:0] RST_GAIN2 = 2'h0;
	localparam logic [3:0] RST_GAIN3 = 4'h0;
	localparam logic [5:0] RST_CODE = 6'h00;
	localparam logic RST_MODE_BIT = 1'h0;

endpackage

// [control_word_decoder.sv]
// Selector decode of a 16-bit control word into per-register write strobes.
module control_word_decoder
	import rf_ctrl_pkg::*;
(
	// Incoming word
	input wire logic wordValid,
	input wire logic [WORD_WIDTH-1:0] word,
	// Strobes for the focus, gain, left/right and sum registers
	output logic [3:0] writeStrobe
);

	// ==========================================================
	// Decoding
	function automatic logic [3:0] selectorToStrobe(input logic [3:0] sel);
		logic [3:0] s;
		s = 4'h0;
		if (sel == SEL_FOCUS) begin
			s = 4'h1;
		end else if (sel == SEL_GAINS) begin
			s = 4'h2;
		end else if (sel == SEL_LR_OFFSETS) begin
			s = 4'h4;
		end else if (sel == SEL_SUM_OFFSET) begin
			s = 4'h8;
		end
		return s;
	endfunction

	always_comb begin
		writeStrobe = 4'h0;
		if (wordValid) begin
			writeStrobe = selectorToStrobe(word[SEL_HI:SEL_LO]); // R1 R16
		end
	end

endmodule

// [offset_router.sv]
// Routing of stored offset codes onto the left, right, phase and sum DACs.
module offset_router
	import rf_ctrl_pkg::*;
(
	// Mode bits
	input wire logic sumInputSelect,
	input wire logic phaseOffsetSourceSelect,
	// Stored codes
	input wire logic [CODE_WIDTH-1:0] leftOffsetCode,
	input wire logic [CODE_WIDTH-1:0] rightOffsetCode,
	input wire logic [CODE_WIDTH-1:0] sumOffsetCode,
	// Routed DAC codes
	output logic [CODE_WIDTH-1:0] leftDac,
	output logic [CODE_WIDTH-1:0] rightDac,
	output logic [CODE_WIDTH-1:0] phaseDac,
	output logic [CODE_WIDTH-1:0] sumDac
);

	// ==========================================================
	// Routing
	always_comb begin
		leftDac = RST_CODE;
		rightDac = RST_CODE;
		phaseDac = RST_CODE;
		sumDac = RST_CODE;
		if (!sumInputSelect) begin
			leftDac = leftOffsetCode; // R8 R14
			rightDac = rightOffsetCode; // R9 R12
		end else if (!phaseOffsetSourceSelect) begin
			phaseDac = rightOffsetCode; // R10 R12
			sumDac = rightOffsetCode; // R10
		end else begin
			phaseDac = leftOffsetCode; // R13 R11 R15
			sumDac = sumOffsetCode; // R13
		end
	end

endmodule

// [axi_lite_host.sv]
// AXI4-Lite host model that stands for the processor writing control words.
module axi_lite_host
	import rf_ctrl_pkg::*;
(
	// Clock
	input wire logic mclk,
	// Write channels
	output logic [ADDR_WIDTH-1:0] awaddr,
	output logic [2:0] awprot,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	// Read channels
	output logic [ADDR_WIDTH-1:0] araddr,
	output logic [2:0] arprot,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// Idle values
	initial begin
		{awaddr, awprot, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arprot, arvalid, rready} = '0;
	end

	// ==========================================================
	// Write: payload is inverted once taken, so nothing relies on stale values.
	task automatic busWrite(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		@(posedge mclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge mclk);
			if (awvalid && awready) begin
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (wvalid && wready) begin
				wvalid <= 1'b0;
				wdata <= ~d;
			end
		end while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask

	// ==========================================================
	// Read
	task automatic busRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge mclk);
			if (arvalid && arready) begin
				arvalid <= 1'b0;
				araddr <= ~a;
			end
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
endmodule

// [tb_focus_rf_gain_offset_regs.sv]
// Self-checking testbench for the focus, RF gain and RF offset registers.
module tb_focus_rf_gain_offset_regs
	import rf_ctrl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// Signals
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] awaddr, araddr;
	logic [2:0] awprot, arprot;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, g1, g2;
	logic altMode, focusEnN;
	logic [4:0] frac;
	logic [3:0] g3;
	logic [5:0] lDac, rDac, pDac, sDac;
	logic [31:0] ctl, dacs;
	logic [15:0] unusedSel = 16'hf610;
	int numErrors = 0;
	int samplesChecked = 0;
	int cycles = 0;

	assign ctl = {17'h0, altMode, focusEnN, frac, g1, g2, g3};
	assign dacs = {8'h0, lDac, rDac, pDac, sDac};

	always #12.5 mclk = ~mclk;

	// ==========================================================
	// Design and host
	focus_rf_gain_offset_regs i_dut (.mclk(mclk), .srst(srst),
		.awaddr(awaddr), .awprot(awprot), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arprot(arprot), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.altStretchTimingMode(altMode), .focusOffsetEnable_n(focusEnN),
		.focusOffsetFraction(frac), .firstStageGain(g1), .secondStageGain(g2),
		.thirdStageGain(g3), .leftOffsetDac(lDac), .rightOffsetDac(rDac),
		.phaseOffsetDac(pDac), .sumOffsetDac(sDac));

	axi_lite_host i_host (.mclk(mclk),
		.awaddr(awaddr), .awprot(awprot), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arprot(arprot), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

	// ==========================================================
	// Checking helpers
	task automatic endSim();
		if (numErrors == 0 && samplesChecked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samplesChecked++;
		if (g !== e) begin
			numErrors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		logic [1:0] r;
		i_host.busWrite(a, d, s, r);
		chk("bresp", {30'h0, er}, {30'h0, r});
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		i_host.busRead(a, d, r);
		chk("rdata", ed, d);
		chk("rresp", {30'h0, er}, {30'h0, r});
	endtask

	// Word with the register selector in the top four bits.
	function automatic logic [31:0] cw(logic [3:0] sel, logic [11:0] f);
		return {16'h0, sel, f};
	endfunction

	// Routed DAC codes for mode bits {source, sum select}.
	function automatic logic [31:0] route(logic [1:0] m, logic [5:0] l, r, s);
		case (m)
			2'b01: return {8'h0, 12'h0, r, r};
			2'b11: return {8'h0, 12'h0, l, s};
			default: return {8'h0, l, r, 12'h0};
		endcase
	endfunction

	// ==========================================================
	// Timeout
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			numErrors++;
			endSim();
		end
	end

	// ==========================================================
	// Tests
	initial begin
		repeat (16) @(posedge mclk);
		srst <= 1'b0;
		chk("ctl", 32'h2000, ctl);
		chk("dacs", 32'h0, dacs);
		rd(ADDR_FOCUS, 32'h2400, RESP_OKAY);
		rd(ADDR_LR_OFFSETS, 32'h4000, RESP_OKAY);
		for (int i = 0; i < 2; i++) begin
			wr(ADDR_COMMAND, cw(SEL_FOCUS, {~i[0], i[0], i[0] ? 5'h1f : 5'h15, 5'h1f}), 4'hf,
				RESP_OKAY);
			chk("ctl", {17'h0, ~i[0], i[0], i[0] ? 5'h1f : 5'h15, 8'h0}, ctl);
			rd(ADDR_FOCUS, cw(SEL_FOCUS, {~i[0], i[0], i[0] ? 5'h1f : 5'h15, 5'h0}),
				RESP_OKAY);
		end
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_COMMAND, cw(SEL_GAINS, {2'(i % 3), 2'(3 - i), 4'(i * 5), 4'hf}), 4'hf,
				RESP_OKAY);
			chk("ctl", {17'h0, 7'h3f, 2'(i % 3), 2'(3 - i), 4'(i * 5)}, ctl);
			rd(ADDR_GAINS, cw(SEL_GAINS, {2'(i % 3), 2'(3 - i), 4'(i * 5), 4'h0}),
				RESP_OKAY);
		end
		for (int k = 0; k < 4; k++) begin
			wr(ADDR_COMMAND, cw(unusedSel[4 * k +: 4], 12'hfff), 4'hf, RESP_OKAY);
		end
		chk("ctl", {17'h0, 7'h3f, 2'h0, 2'h0, 4'hf}, ctl);
		rd(ADDR_LR_OFFSETS, 32'h4000, RESP_OKAY);
		wr(ADDR_COMMAND, cw(SEL_LR_OFFSETS, {6'h2a, 6'h15}), 4'hf, RESP_OKAY);
		wr(ADDR_COMMAND, cw(SEL_SUM_OFFSET, {6'h3f, 6'h33}), 4'hf, RESP_OKAY);
		for (int m = 0; m < 4; m++) begin
			wr(ADDR_MODE, {20'h0, m[1], 10'h0, m[0]}, 4'hf, RESP_OKAY);
			chk("dacs", route(2'(m), 6'h2a, 6'h15, 6'h33), dacs);
			rd(ADDR_ROUTED, route(2'(m), 6'h2a, 6'h15, 6'h33), RESP_OKAY);
			rd(ADDR_MODE, {20'h0, m[1], 10'h0, m[0]}, RESP_OKAY);
		end
		wr(ADDR_COMMAND, cw(SEL_LR_OFFSETS, {6'h0c, 6'h31}), 4'hf, RESP_OKAY);
		chk("dacs", route(2'b11, 6'h0c, 6'h31, 6'h33), dacs);
		wr(ADDR_MODE, 32'h1, 4'hf, RESP_OKAY);
		wr(ADDR_COMMAND, cw(SEL_SUM_OFFSET, 12'h007), 4'hf, RESP_OKAY);
		chk("dacs", route(2'b01, 6'h0c, 6'h31, 6'h07), dacs);
		wr(ADDR_FOCUS, 32'h0, 4'hf, RESP_SLVERR);
		chk("ctl", {17'h0, 7'h3f, 2'h0, 2'h0, 4'hf}, ctl);
		wr(ADDR_COMMAND, cw(SEL_SUM_OFFSET, 12'h001), 4'hc, RESP_SLVERR);
		wr(ADDR_COMMAND, cw(SEL_SUM_OFFSET, 12'h001), 4'h1, RESP_SLVERR);
		rd(ADDR_SUM_OFFSET, cw(SEL_SUM_OFFSET, 12'h007), RESP_OKAY);
		rd(8'h80, 32'h0, RESP_SLVERR);
		rd(ADDR_COMMAND, 32'h0, RESP_OKAY);
		srst <= 1'b1;
		repeat (2) @(posedge mclk);
		srst <= 1'b0;
		chk("ctl", 32'h2000, ctl);
		chk("dacs", 32'h0, dacs);
		rd(ADDR_MODE, 32'h0, RESP_OKAY);
		rd(ADDR_SUM_OFFSET, 32'h5000, RESP_OKAY);
		endSim();
	end
endmodule
